/* File: common/imc_pkg.sv */
// Constants, types and helpers shared by the input mapping and mode control block.
package imc_pkg;

   // ----------------------------------------
   // Widths and pin positions
   // ----------------------------------------
   localparam int CH_W = 8;
   localparam int SYNC_W = 4;
   localparam int IDX_IN_A = 0;
   localparam int IDX_IN_B = 1;
   localparam int IDX_SLEEP = 2;
   localparam int IDX_CS = 3;

   // ----------------------------------------
   // Default channel assignment and reset values
   // ----------------------------------------
   localparam int DEF_CH_A = 2;
   localparam int DEF_CH_B = 3;
   localparam logic [CH_W-1:0] OUT_RST = 8'h00;
   // Pins read low after reset, chip select reads idle (high).
   localparam logic [SYNC_W-1:0] SYNC_RST = 4'h8;

   // ----------------------------------------
   // Register select codes on the write port
   // ----------------------------------------
   localparam logic [1:0] SEL_OUT = 2'h0;
   localparam logic [1:0] SEL_MAP_A = 2'h1;
   localparam logic [1:0] SEL_MAP_B = 2'h2;

   // ----------------------------------------
   // Operating modes
   // ----------------------------------------
   typedef enum logic [1:0] {MODE_NORMAL, MODE_LIMP, MODE_SLEEP} imc_mode_e;

   // One-hot channel pattern for a channel index.
   function automatic logic [CH_W-1:0] imc_onehot(input int idx);
      imc_onehot = CH_W'(1) << idx;
   endfunction

endpackage

/* File: common/imc_sync_if.sv */
// Carrier for the filtered pin levels between the synchroniser and the control logic.
`timescale 1ns/1ps
interface imc_sync_if #(
   parameter int W = 4
);
   logic [W-1:0] level;
   modport src (output level);
   modport dst (input level);
endinterface

/* File: logic/imc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module imc_pin_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // Raw pins
   input wire logic [W-1:0] pin_i,
   // Filtered levels
   imc_sync_if.src sync
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] level_ff;
   logic [W-1:0] nxt_level;

   // A bit is taken only once the second and third stages agree, so one
   // metastable sample on the first stage never reaches the logic.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
      end
   end

   // Stage registers; the first stage feeds only the second.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         level_ff <= RST_VAL;
      end else begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         level_ff <= nxt_level;
      end
   end

   assign sync.level = level_ff;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_sync_agree;
      (level_ff != $past(level_ff)) |-> ($past(s2_ff) == $past(s3_ff));
   endproperty
   a_sync_agree: assert property (p_sync_agree)
      else $error("Filtered level changed without stage agreement.");

endmodule

/* File: logic/imc_input_mapping_ctrl.sv */
// Input mapping, channel drive and sleep/limp-home mode control.
`timescale 1ns/1ps
module imc_input_mapping_ctrl (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // Control pins from the controller
   input wire logic direct_input_a_i,
   input wire logic direct_input_b_i,
   input wire logic sleep_ctrl_i,
   input wire logic chip_select_low_n_i,
   // Register write port from the serial decoder
   input wire logic reg_wr_i,
   input wire logic [1:0] reg_sel_i,
   input wire logic [imc_pkg::CH_W-1:0] reg_wr_data_i,
   // Register readback
   output logic [imc_pkg::CH_W-1:0] out_ctrl_o,
   output logic [imc_pkg::CH_W-1:0] input_a_channel_map_o,
   output logic [imc_pkg::CH_W-1:0] input_b_channel_map_o,
   output logic [1:0] input_level_monitor_o,
   // Channel drive
   output logic [imc_pkg::CH_W-1:0] channel_drive_o,
   // Mode and supervision
   output logic mode_limp_o,
   output logic mode_sleep_o,
   output logic uv_detect_en_o,
   output logic spi_enable_o,
   output logic so_oe_o
);

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   imc_sync_if #(.W(imc_pkg::SYNC_W)) sync_if ();

   imc_pin_sync #(
      .W(imc_pkg::SYNC_W),
      .RST_VAL(imc_pkg::SYNC_RST)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .pin_i({chip_select_low_n_i, sleep_ctrl_i, direct_input_b_i, direct_input_a_i}),
      .sync(sync_if.src)
   );

   logic in_a;
   logic in_b;
   logic sleep_lvl;
   logic cs_n_lvl;

   assign in_a = sync_if.level[imc_pkg::IDX_IN_A];
   assign in_b = sync_if.level[imc_pkg::IDX_IN_B];
   assign sleep_lvl = sync_if.level[imc_pkg::IDX_SLEEP];
   assign cs_n_lvl = sync_if.level[imc_pkg::IDX_CS];

   localparam logic [imc_pkg::CH_W-1:0] MAP_A_RST = imc_pkg::imc_onehot(imc_pkg::DEF_CH_A);
   localparam logic [imc_pkg::CH_W-1:0] MAP_B_RST = imc_pkg::imc_onehot(imc_pkg::DEF_CH_B);

   // ----------------------------------------
   // Register bank
   // ----------------------------------------
   logic [imc_pkg::CH_W-1:0] out_ctrl_ff;
   logic [imc_pkg::CH_W-1:0] map_a_ff;
   logic [imc_pkg::CH_W-1:0] map_b_ff;
   logic [imc_pkg::CH_W-1:0] nxt_out_ctrl;
   logic [imc_pkg::CH_W-1:0] nxt_map_a;
   logic [imc_pkg::CH_W-1:0] nxt_map_b;
   logic wr_seen_ff;
   logic nxt_wr_seen;

   // A low sleep pin holds the bank at defaults and also blocks writes, so
   // a write racing the pin edge cannot leave a stale mapping behind.
   always_comb begin
      nxt_out_ctrl = out_ctrl_ff;
      nxt_map_a = map_a_ff;
      nxt_map_b = map_b_ff;
      nxt_wr_seen = wr_seen_ff;
      if (!sleep_lvl) begin
         nxt_out_ctrl = imc_pkg::OUT_RST;
         nxt_map_a = MAP_A_RST;
         nxt_map_b = MAP_B_RST;
      end else if (reg_wr_i) begin
         case (reg_sel_i)
            imc_pkg::SEL_OUT: begin
               nxt_out_ctrl = reg_wr_data_i;
            end
            imc_pkg::SEL_MAP_A: begin
               nxt_map_a = reg_wr_data_i;
               nxt_wr_seen = 1'b1;
            end
            imc_pkg::SEL_MAP_B: begin
               nxt_map_b = reg_wr_data_i;
               nxt_wr_seen = 1'b1;
            end
            default: begin
               nxt_out_ctrl = out_ctrl_ff;
            end
         endcase
      end
   end

   // Bank registers come out of reset with the default mapping.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_ctrl_ff <= imc_pkg::OUT_RST;
         map_a_ff <= MAP_A_RST;
         map_b_ff <= MAP_B_RST;
         wr_seen_ff <= 1'b0;
      end else begin
         out_ctrl_ff <= nxt_out_ctrl;
         map_a_ff <= nxt_map_a;
         map_b_ff <= nxt_map_b;
         wr_seen_ff <= nxt_wr_seen;
      end
   end

   // ----------------------------------------
   // Mode and channel drive
   // ----------------------------------------
   imc_pkg::imc_mode_e nxt_mode;
   logic limp_ff;
   logic sleep_ff;
   logic nxt_limp;
   logic nxt_sleep;
   logic [imc_pkg::CH_W-1:0] drive_ff;
   logic [imc_pkg::CH_W-1:0] nxt_drive;
   logic [1:0] monitor_ff;
   logic uv_en_ff;
   logic spi_en_ff;
   logic so_oe_ff;
   logic nxt_uv_en;
   logic nxt_spi_en;
   logic nxt_so_oe;

   // Mode follows the sleep pin and the inputs directly; in limp-home only the
   // fixed default channels run, independent of the bank contents.
   always_comb begin
      nxt_mode = imc_pkg::MODE_NORMAL;
      nxt_drive = out_ctrl_ff | ({imc_pkg::CH_W{in_a}} & map_a_ff)
                  | ({imc_pkg::CH_W{in_b}} & map_b_ff);
      if (!sleep_lvl) begin
         if (in_a || in_b) begin
            nxt_mode = imc_pkg::MODE_LIMP;
            nxt_drive = ({imc_pkg::CH_W{in_a}} & MAP_A_RST)
                        | ({imc_pkg::CH_W{in_b}} & MAP_B_RST);
         end else begin
            nxt_mode = imc_pkg::MODE_SLEEP;
            nxt_drive = imc_pkg::OUT_RST;
         end
      end
      case (nxt_mode)
         imc_pkg::MODE_SLEEP: begin
            nxt_uv_en = 1'b0;
            nxt_spi_en = 1'b0;
         end
         default: begin
            nxt_uv_en = 1'b1;
            nxt_spi_en = 1'b1;
         end
      endcase
      nxt_so_oe = nxt_spi_en && !cs_n_lvl;
      // Mode flags are decoded before the register so the ports come from flops.
      nxt_limp = (nxt_mode == imc_pkg::MODE_LIMP);
      nxt_sleep = (nxt_mode == imc_pkg::MODE_SLEEP);
   end

   // Output registers; the monitor tracks the pins in every mode.
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         limp_ff <= 1'b0;
         sleep_ff <= 1'b1;
         drive_ff <= imc_pkg::OUT_RST;
         monitor_ff <= 2'h0;
         uv_en_ff <= 1'b0;
         spi_en_ff <= 1'b0;
         so_oe_ff <= 1'b0;
      end else begin
         limp_ff <= nxt_limp;
         sleep_ff <= nxt_sleep;
         drive_ff <= nxt_drive;
         monitor_ff <= {in_b, in_a};
         uv_en_ff <= nxt_uv_en;
         spi_en_ff <= nxt_spi_en;
         so_oe_ff <= nxt_so_oe;
      end
   end

   assign out_ctrl_o = out_ctrl_ff;
   assign input_a_channel_map_o = map_a_ff;
   assign input_b_channel_map_o = map_b_ff;
   assign input_level_monitor_o = monitor_ff;
   assign channel_drive_o = drive_ff;
   assign mode_limp_o = limp_ff;
   assign mode_sleep_o = sleep_ff;
   assign uv_detect_en_o = uv_en_ff;
   assign spi_enable_o = spi_en_ff;
   assign so_oe_o = so_oe_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_default_map;
      !wr_seen_ff |-> (map_a_ff == MAP_A_RST) && (map_b_ff == MAP_B_RST);
   endproperty
   a_default_map: assert property (p_default_map)
      else $error("Mapping left default without a map write.");

   property p_map_write;
      (sleep_lvl && reg_wr_i && reg_sel_i == imc_pkg::SEL_MAP_B)
         |=> map_b_ff == $past(reg_wr_data_i);
   endproperty
   a_map_write: assert property (p_map_write)
      else $error("Input B map did not take the written value.");

   property p_or_drive;
      $past(sleep_lvl) |-> channel_drive_o == ($past(out_ctrl_ff)
         | ({imc_pkg::CH_W{$past(in_a)}} & $past(map_a_ff))
         | ({imc_pkg::CH_W{$past(in_b)}} & $past(map_b_ff)));
   endproperty
   a_or_drive: assert property (p_or_drive)
      else $error("Channel drive is not the OR of control and mapped inputs.");

   property p_monitor;
      ##1 input_level_monitor_o == $past({in_b, in_a});
   endproperty
   a_monitor: assert property (p_monitor)
      else $error("Input monitor does not follow the pins.");

   property p_monitor_limp;
      mode_limp_o && (in_a != $past(in_a)) |=> input_level_monitor_o[0] == $past(in_a);
   endproperty
   a_monitor_limp: assert property (p_monitor_limp)
      else $error("Input monitor frozen in limp-home.");

   property p_limp;
      !$past(sleep_lvl) && ($past(in_a) || $past(in_b)) |-> mode_limp_o
         && channel_drive_o == (({imc_pkg::CH_W{$past(in_a)}} & MAP_A_RST)
         | ({imc_pkg::CH_W{$past(in_b)}} & MAP_B_RST));
   endproperty
   a_limp: assert property (p_limp)
      else $error("Limp-home entry or its channels wrong.");

   property p_sleep;
      !sleep_lvl && !in_a && !in_b |=> mode_sleep_o && channel_drive_o == imc_pkg::OUT_RST;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("Sleep mode not entered.");

   property p_bank_reset;
      !sleep_lvl |=> out_ctrl_ff == imc_pkg::OUT_RST && map_a_ff == MAP_A_RST
         && map_b_ff == MAP_B_RST;
   endproperty
   a_bank_reset: assert property (p_bank_reset)
      else $error("Register bank not at defaults under low sleep pin.");

   property p_uv_off;
      uv_detect_en_o == !mode_sleep_o;
   endproperty
   a_uv_off: assert property (p_uv_off)
      else $error("Undervoltage detector enable disagrees with sleep mode.");

   property p_so_hiz;
      mode_sleep_o |-> !so_oe_o && !spi_enable_o;
   endproperty
   a_so_hiz: assert property (p_so_hiz)
      else $error("Serial output driven in sleep mode.");

endmodule

/* File: bench/imc_host_model.sv */
// Behavioural controller that drives the direct inputs, sleep control and chip select pins.
`timescale 1ns/1ps
module imc_host_model #(
   parameter int HOLD = 8
) (
   // Clock
   input wire logic core_clk_i,
   // Requested pin levels from the bench
   input wire logic req_a_i,
   input wire logic req_b_i,
   input wire logic req_sleep_i,
   input wire logic req_cs_n_i,
   // Pins towards the device
   output logic direct_input_a_o,
   output logic direct_input_b_o,
   output logic sleep_ctrl_o,
   output logic chip_select_low_n_o
);
   int hold_cnt = 0;

   // Pins start idle: inputs low, sleep control high, chip select released.
   initial begin
      direct_input_a_o = 1'b0;
      direct_input_b_o = 1'b0;
      sleep_ctrl_o = 1'b1;
      chip_select_low_n_o = 1'b1;
   end

   // A sleep level change is held for HOLD+1 cycles before the next one is allowed.
   // Chip select stays released while the device sleeps, since it would not answer.
   always @(posedge core_clk_i) begin
      direct_input_a_o <= req_a_i;
      direct_input_b_o <= req_b_i;
      if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end else if (req_sleep_i != sleep_ctrl_o) begin
         sleep_ctrl_o <= req_sleep_i;
         hold_cnt <= HOLD;
      end
      chip_select_low_n_o <= (!req_sleep_i && !req_a_i && !req_b_i) ? 1'b1 : req_cs_n_i;
   end
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the input mapping and mode control block.
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [7:0] oc, ma, mb, drv;
      logic [1:0] mon;
      logic [4:0] fl;
   } imc_note_s;

   logic core_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic ra = 1'b0, rb = 1'b0, rs = 1'b1, rc = 1'b1;
   logic a_w, b_w, s_w, c_w;
   logic reg_wr_i = 1'b0;
   logic [1:0] reg_sel_i = 2'h0;
   logic [7:0] reg_wr_data_i = 8'h00;
   logic [7:0] oc_o, ma_o, mb_o, drv_o;
   logic [1:0] mon_o;
   logic limp_o, slp_o, uv_o, spi_o, so_o;
   int fail_count = 0;
   int checks = 0;
   imc_note_s notes[$];
   logic sample_req = 1'b0;
   logic [31:0] lfsr = 32'h0001530f;
   logic [7:0] m_oc = 8'h00, m_ma = 8'h04, m_mb = 8'h08;

   // Free-running 10 MHz clock.
   always #50 core_clk_i = ~core_clk_i;

   imc_host_model host (.core_clk_i(core_clk_i), .req_a_i(ra), .req_b_i(rb), .req_sleep_i(rs),
      .req_cs_n_i(rc), .direct_input_a_o(a_w), .direct_input_b_o(b_w), .sleep_ctrl_o(s_w),
      .chip_select_low_n_o(c_w));

   imc_input_mapping_ctrl uut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .direct_input_a_i(a_w), .direct_input_b_i(b_w), .sleep_ctrl_i(s_w),
      .chip_select_low_n_i(c_w), .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i),
      .reg_wr_data_i(reg_wr_data_i), .out_ctrl_o(oc_o), .input_a_channel_map_o(ma_o),
      .input_b_channel_map_o(mb_o), .input_level_monitor_o(mon_o), .channel_drive_o(drv_o),
      .mode_limp_o(limp_o), .mode_sleep_o(slp_o), .uv_detect_en_o(uv_o), .spi_enable_o(spi_o),
      .so_oe_o(so_o));

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Compares one result field; an unknown never matches.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Result watcher: takes the oldest note whenever a settled result is announced.
   // ----------------------------------------
   always @(sample_req) begin : watch
      imc_note_s n;
      // Look half a cycle later so no register update of the same edge is raced.
      @(negedge core_clk_i);
      n = notes.pop_front();
      chk(oc_o, n.oc);
      chk(ma_o, n.ma);
      chk(mb_o, n.mb);
      chk(drv_o, n.drv);
      chk({6'h00, mon_o}, {6'h00, n.mon});
      chk({7'h00, limp_o}, {7'h00, n.fl[4]});
      chk({7'h00, slp_o}, {7'h00, n.fl[3]});
      chk({7'h00, uv_o}, {7'h00, n.fl[2]});
      chk({6'h00, spi_o, so_o}, {6'h00, n.fl[1:0]});
   end

   // ----------------------------------------
   // Stimulus: random pin levels and writes, with the expected result noted.
   // ----------------------------------------
   initial begin : main
      logic [31:0] r;
      logic a, b, s, c, lh, sl;
      logic [1:0] sel;
      logic [7:0] drv;
      repeat (4) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      for (int i = 0; i < 60; i++) begin
         lfsr = lfsr_next(lfsr);
         r = lfsr;
         a = (i == 0) ? 1'b0 : r[0];
         b = (i == 0) ? 1'b0 : r[1];
         s = r[2] | r[3] | (i == 0);
         c = r[4];
         sel = (i == 0) ? 2'h3 : r[9:8];
         ra <= a;
         rb <= b;
         rs <= s;
         rc <= c;
         // A low sleep pin returns the whole bank to its defaults.
         if (!s) begin
            m_oc = 8'h00;
            m_ma = 8'h04;
            m_mb = 8'h08;
         end
         repeat (9) @(posedge core_clk_i);
         if (s) begin
            reg_wr_i <= 1'b1;
            reg_sel_i <= sel;
            reg_wr_data_i <= r[23:16];
            if (sel == imc_pkg::SEL_OUT) m_oc = r[23:16];
            if (sel == imc_pkg::SEL_MAP_A) m_ma = r[23:16];
            if (sel == imc_pkg::SEL_MAP_B) m_mb = r[23:16];
            @(posedge core_clk_i);
            reg_wr_i <= 1'b0;
         end
         repeat (3) @(posedge core_clk_i);
         lh = !s && (a || b);
         sl = !s && !a && !b;
         drv = m_oc | (a ? m_ma : 8'h00) | (b ? m_mb : 8'h00);
         if (lh) drv = (a ? 8'h01 << imc_pkg::DEF_CH_A : 8'h00) |
            (b ? 8'h01 << imc_pkg::DEF_CH_B : 8'h00);
         if (sl) drv = 8'h00;
         notes.push_back('{m_oc, m_ma, m_mb, drv, {b, a}, {lh, sl, !sl, !sl, !sl && !c}});
         sample_req <= ~sample_req;
      end
      @(posedge core_clk_i);
      conclude();
   end

   // Cuts a hang short well beyond the expected run of 732 to 791 cycles.
   initial begin : watchdog
      #500000;
      fail_count++;
      conclude();
   end
endmodule
